// ===== core/mpu_mmu_pkg.sv
// Shared constants, types and helpers for the retention MPU and SRAM page MMU block
`default_nettype none
package mpu_mmu_pkg;

   // ----------------------------------------
   // Guarded address windows
   // ----------------------------------------
   localparam logic [31:0] FAST_LO_BASE = 32'h3FF8_0000;
   localparam logic [31:0] FAST_HI_BASE = 32'h400C_0000;
   localparam logic [31:0] SLOW_BASE = 32'h5000_0000;
   localparam logic [31:0] RETN_SIZE = 32'h0000_2000;
   localparam logic [31:0] INSTR_BASE = 32'h4008_0000;
   localparam logic [31:0] DATA_BASE = 32'h3FFC_0000;
   localparam logic [31:0] MMU_RANGE = 32'h0002_0000;

   // ----------------------------------------
   // Page geometry and rights
   // ----------------------------------------
   localparam logic [1:0] PSZ_8K = 2'h0;
   localparam logic [1:0] PSZ_4K = 2'h1;
   localparam logic [1:0] PSZ_2K = 2'h2;
   localparam logic [4:0] SHIFT_8K = 5'h0D;
   localparam logic [4:0] SHIFT_4K = 5'h0C;
   localparam logic [4:0] SHIFT_2K = 5'h0B;
   localparam logic [16:0] PAGE_COUNT = 17'h0_0010;
   localparam logic [16:0] ONE_17 = 17'h0_0001;
   localparam logic [2:0] RIGHTS_ALL = 3'h1;
   localparam logic [2:0] PID_OS0 = 3'h0;
   localparam logic [2:0] PID_FIRST_APP = 3'h2;

   // ----------------------------------------
   // Register map (byte offsets, low address bits)
   // ----------------------------------------
   localparam int WB_ADR_W = 8;
   localparam logic [7:0] OFS_FAST = 8'h00;
   localparam logic [7:0] OFS_SLOW = 8'h04;
   localparam logic [7:0] OFS_IPSZ = 8'h08;
   localparam logic [7:0] OFS_DPSZ = 8'h0C;
   localparam logic [7:0] OFS_VSTAT = 8'h10;
   localparam logic [7:0] OFS_VADDR = 8'h14;
   localparam logic [7:0] OFS_VCNT = 8'h18;
   localparam logic [1:0] MAP_SEL_I = 2'h1;
   localparam logic [1:0] MAP_SEL_D = 2'h2;
   localparam int VSTAT_CLR_BIT = 0;

   // ----------------------------------------
   // Reset values and violation counter limit
   // ----------------------------------------
   localparam logic [7:0] FAST_ALLOW_RST = 8'h03;
   localparam logic [5:0] SLOW_ALLOW_RST = 6'h00;
   localparam logic [1:0] PSZ_RST = 2'h0;
   localparam logic [15:0] VCNT_MAX = 16'hFFFF;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {REGION_NONE, REGION_FAST, REGION_SLOW, REGION_INSTR, REGION_DATA} region_t;

   typedef struct packed {
      logic [2:0] rights;
      logic [3:0] vpage;
   } map_entry_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [2:0] process_ident;
      logic [31:0] addr;
   } acc_req_t;

   typedef struct packed {
      logic valid;
      logic grant;
      logic write;
      region_t region;
      logic [31:0] phys_addr;
   } acc_resp_t;

   typedef struct packed {
      logic [7:0] fast_allow;
      logic [5:0] slow_allow;
      logic [1:0] ipsz;
      logic [1:0] dpsz;
      map_entry_t [15:0] imap;
      map_entry_t [15:0] dmap;
      logic ack;
      logic [31:0] rdat;
      acc_resp_t resp;
      logic viol;
      logic [2:0] viol_pid;
      logic viol_wr;
      region_t viol_region;
      logic [31:0] viol_addr;
      logic [15:0] viol_cnt;
   } state_t;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic in_window(input logic [31:0] addr, input logic [31:0] base, input logic [31:0] size);
      logic [31:0] d;
      d = addr - base;
      return d < size;
   endfunction

   function automatic logic is_os_pid(input logic [2:0] process_ident);
      return process_ident[2:1] == 2'h0;
   endfunction

endpackage
`default_nettype wire

// ===== core/retention_mpu_check.sv
// Allow check for the fast and slow retention memories
`default_nettype none
module retention_mpu_check (
   input wire logic [2:0] process_ident,
   input wire logic [31:0] addr,
   input wire logic [7:0] fast_allow,
   input wire logic [5:0] slow_allow,
   output logic fast_hit,
   output logic slow_hit,
   output logic grant
);

   logic [2:0] slow_idx;
   logic [7:0] slow_ext;

   // Both fast aliases share one allow byte; slow grants the OS ids unconditionally
   always_comb begin
      fast_hit = mpu_mmu_pkg::in_window(addr, mpu_mmu_pkg::FAST_LO_BASE, mpu_mmu_pkg::RETN_SIZE) |
                 mpu_mmu_pkg::in_window(addr, mpu_mmu_pkg::FAST_HI_BASE, mpu_mmu_pkg::RETN_SIZE); // R03
      slow_hit = mpu_mmu_pkg::in_window(addr, mpu_mmu_pkg::SLOW_BASE, mpu_mmu_pkg::RETN_SIZE);
      slow_idx = process_ident - mpu_mmu_pkg::PID_FIRST_APP; // R04
      // Padded so the wrapped index of ids 0 and 1 stays inside the vector
      slow_ext = {2'h0, slow_allow};
      grant = 1'b0;
      if (fast_hit) begin
         grant = fast_allow[process_ident]; // R01 R03
      end else if (slow_hit) begin
         grant = mpu_mmu_pkg::is_os_pid(process_ident) | slow_ext[slow_idx]; // R01 R02 R04
      end
   end

endmodule
`default_nettype wire

// ===== core/page_mmu_lookup.sv
// Page translation and rights check for one upper-128 KB SRAM window
`default_nettype none
module page_mmu_lookup #(
   parameter logic [31:0] BASE = 32'h0000_0000,
   parameter bit READ_ONLY = 1'b0
) (
   input wire logic [2:0] process_ident,
   input wire logic [31:0] addr,
   input wire logic write,
   input wire logic [1:0] psz,
   input wire mpu_mmu_pkg::map_entry_t [15:0] map,
   output logic in_range,
   output logic grant,
   output logic [31:0] phys
);

   logic [31:0] ofs;
   logic [16:0] o17;
   logic [16:0] pg_full;
   logic [16:0] mask;
   logic [16:0] new_ofs;
   logic [4:0] shift;
   logic [3:0] vpage;
   logic [3:0] ppage;
   logic covered;
   logic hit;

   // Reverse search: each entry names the virtual page that reaches its physical page
   always_comb begin
      ofs = addr - BASE;
      in_range = ofs < mpu_mmu_pkg::MMU_RANGE; // R06
      o17 = ofs[16:0];
      case (psz) // R08
         mpu_mmu_pkg::PSZ_4K: shift = mpu_mmu_pkg::SHIFT_4K;
         mpu_mmu_pkg::PSZ_2K: shift = mpu_mmu_pkg::SHIFT_2K;
         default: shift = mpu_mmu_pkg::SHIFT_8K;
      endcase
      pg_full = o17 >> shift; // R13
      covered = pg_full < mpu_mmu_pkg::PAGE_COUNT; // R07 R11
      vpage = pg_full[3:0];
      mask = (mpu_mmu_pkg::ONE_17 << shift) - mpu_mmu_pkg::ONE_17;
      hit = 1'b0;
      ppage = 4'h0;
      // Descending walk so the lowest matching physical page wins
      for (int p = 15; p >= 0; p--) begin
         if (map[p].vpage == vpage &&
             (map[p].rights == mpu_mmu_pkg::RIGHTS_ALL || map[p].rights == process_ident)) begin // R14 R15
            hit = 1'b1;
            ppage = 4'(p);
         end
      end
      new_ofs = ({13'h0000, ppage} << shift) | (o17 & mask); // R10
      if (mpu_mmu_pkg::is_os_pid(process_ident)) begin
         grant = 1'b1; // R09 R12
         phys = addr; // R09
      end else begin
         grant = covered & hit & ~(READ_ONLY & write); // R12 R17
         phys = BASE + {15'h0000, new_ofs}; // R10
      end
   end

endmodule
`default_nettype wire

// ===== core/mem_guard.sv
// Top of the retention MPUs and SRAM page MMUs with their Wishbone register slave
//
// Design decisions made here: the address map and the Wishbone register port.
`default_nettype none

// How it works
// R01 - Fast and slow retention memories each have an MPU where a set per-id allow bit grants access.
// R02 - Process ids 0 and 1 always reach the slow retention memory regardless of allow bits.
// R03 - Both fast memory aliases use the same allow byte, bit n for process id n.
// R04 - The slow allow register holds bits 0 to 5 for process ids 2 to 7.
// R05 - Only id 0 writes the fast allow byte; ids 0 or 1 write the slow allow bits.
// R06 - Instruction and data upper windows are each guarded and translated by an MMU.
// R07 - Each MMU splits its window into exactly 16 pages.
// R08 - Each side has its own page size select: 0 is 8 KB, 1 is 4 KB, 2 is 2 KB.
// R09 - For ids 0 and 1 every virtual page goes to the same physical page with full access.
// R10 - For ids 2 to 7 an access is redirected to the mapped physical page keeping its offset.
// R11 - With 4 KB pages the top 64 KB and with 2 KB pages the top 96 KB lie outside the pages.
// R12 - The area outside the pages is open to ids 0 and 1 and denied to all others.
// R13 - Page n spans base plus size times n up to the next page, from the side's base.
// R14 - Each MMU has 16 map registers, one per physical page, naming the virtual page and rights.
// R15 - Map bits 6 to 4 are rights (0 none, 1 all, 2-7 that id only), bits 3 to 0 the virtual page.
// R16 - Map registers and page size selects take writes only from ids 0 or 1.
// R17 - For ids 2 to 7 instruction pages are read only and data pages read and write.
module mem_guard (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [mpu_mmu_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [2:0] wb_pid_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire mpu_mmu_pkg::acc_req_t acc_req,
   output mpu_mmu_pkg::acc_resp_t acc_resp
);

   // ----------------------------------------
   // State and decode signals
   // ----------------------------------------
   mpu_mmu_pkg::state_t s_r;
   mpu_mmu_pkg::state_t s_nxt;

   logic bus_req;
   logic wr;
   logic os_writer;
   logic [1:0] map_sel;
   logic [3:0] map_idx;
   logic fast_hit;
   logic slow_hit;
   logic retn_grant;
   logic i_in;
   logic i_grant;
   logic [31:0] i_phys;
   logic d_in;
   logic d_grant;
   logic [31:0] d_phys;
   logic deny;
   logic clr_viol;

   // ----------------------------------------
   // Guard units
   // ----------------------------------------

   // Retention memory allow checks
   retention_mpu_check retn_u (
      .process_ident(acc_req.process_ident),
      .addr(acc_req.addr),
      .fast_allow(s_r.fast_allow),
      .slow_allow(s_r.slow_allow),
      .fast_hit(fast_hit),
      .slow_hit(slow_hit),
      .grant(retn_grant)
   );

   // Instruction side is fetched code, so applications get no writes there
   page_mmu_lookup #(
      .BASE(mpu_mmu_pkg::INSTR_BASE),
      .READ_ONLY(1'b1)
   ) instr_u (
      .process_ident(acc_req.process_ident),
      .addr(acc_req.addr),
      .write(acc_req.write),
      .psz(s_r.ipsz),
      .map(s_r.imap),
      .in_range(i_in),
      .grant(i_grant),
      .phys(i_phys)
   );

   // Data side lets applications write their own pages
   page_mmu_lookup #(
      .BASE(mpu_mmu_pkg::DATA_BASE),
      .READ_ONLY(1'b0)
   ) data_u (
      .process_ident(acc_req.process_ident),
      .addr(acc_req.addr),
      .write(acc_req.write),
      .psz(s_r.dpsz),
      .map(s_r.dmap),
      .in_range(d_in),
      .grant(d_grant),
      .phys(d_phys)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;

      // Classic single cycle: answer one clock after the strobe, then drop
      bus_req = wb_cyc_i & wb_stb_i & ~s_r.ack;
      wr = bus_req & wb_we_i & wb_sel_i[0];
      os_writer = mpu_mmu_pkg::is_os_pid(wb_pid_i);
      map_sel = wb_adr_i[7:6];
      map_idx = wb_adr_i[5:2];
      s_nxt.ack = bus_req;
      s_nxt.rdat = 32'h0000_0000;

      // Register read mux; unmapped offsets read as zero
      if (bus_req && !wb_we_i) begin
         if (map_sel == mpu_mmu_pkg::MAP_SEL_I) begin
            s_nxt.rdat = {25'h000_0000, s_r.imap[map_idx]};
         end else if (map_sel == mpu_mmu_pkg::MAP_SEL_D) begin
            s_nxt.rdat = {25'h000_0000, s_r.dmap[map_idx]};
         end else begin
            case (wb_adr_i)
               mpu_mmu_pkg::OFS_FAST: s_nxt.rdat = {24'h00_0000, s_r.fast_allow};
               mpu_mmu_pkg::OFS_SLOW: s_nxt.rdat = {26'h000_0000, s_r.slow_allow};
               mpu_mmu_pkg::OFS_IPSZ: s_nxt.rdat = {30'h0000_0000, s_r.ipsz};
               mpu_mmu_pkg::OFS_DPSZ: s_nxt.rdat = {30'h0000_0000, s_r.dpsz};
               mpu_mmu_pkg::OFS_VSTAT: begin
                  s_nxt.rdat = {17'h0_0000, s_r.viol_region, 3'h0, s_r.viol_wr, 1'h0,
                                s_r.viol_pid, 3'h0, s_r.viol};
               end
               mpu_mmu_pkg::OFS_VADDR: s_nxt.rdat = s_r.viol_addr;
               mpu_mmu_pkg::OFS_VCNT: s_nxt.rdat = {16'h0000, s_r.viol_cnt};
               default: s_nxt.rdat = 32'h0000_0000;
            endcase
         end
      end

      // Writes from a disallowed id are acknowledged but leave the register alone
      if (wr && wb_adr_i == mpu_mmu_pkg::OFS_FAST && wb_pid_i == mpu_mmu_pkg::PID_OS0) begin
         s_nxt.fast_allow = wb_dat_i[7:0]; // R05
      end
      if (wr && wb_adr_i == mpu_mmu_pkg::OFS_SLOW && os_writer) begin
         s_nxt.slow_allow = wb_dat_i[5:0]; // R05
      end
      if (wr && wb_adr_i == mpu_mmu_pkg::OFS_IPSZ && os_writer) begin
         s_nxt.ipsz = wb_dat_i[1:0]; // R16
      end
      if (wr && wb_adr_i == mpu_mmu_pkg::OFS_DPSZ && os_writer) begin
         s_nxt.dpsz = wb_dat_i[1:0]; // R16
      end
      if (wr && os_writer && map_sel == mpu_mmu_pkg::MAP_SEL_I) begin
         s_nxt.imap[map_idx] = wb_dat_i[6:0]; // R14 R16
      end
      if (wr && os_writer && map_sel == mpu_mmu_pkg::MAP_SEL_D) begin
         s_nxt.dmap[map_idx] = wb_dat_i[6:0]; // R14 R16
      end
      clr_viol = wr && os_writer && wb_adr_i == mpu_mmu_pkg::OFS_VSTAT && wb_dat_i[mpu_mmu_pkg::VSTAT_CLR_BIT];

      // Access path: one registered answer per request, no stall
      s_nxt.resp.valid = acc_req.valid;
      s_nxt.resp.write = acc_req.write;
      s_nxt.resp.grant = 1'b1;
      s_nxt.resp.region = mpu_mmu_pkg::REGION_NONE;
      s_nxt.resp.phys_addr = acc_req.addr;
      if (fast_hit) begin
         s_nxt.resp.grant = retn_grant; // R01
         s_nxt.resp.region = mpu_mmu_pkg::REGION_FAST;
      end else if (slow_hit) begin
         s_nxt.resp.grant = retn_grant; // R02
         s_nxt.resp.region = mpu_mmu_pkg::REGION_SLOW;
      end else if (i_in) begin
         s_nxt.resp.grant = i_grant; // R06 R17
         s_nxt.resp.region = mpu_mmu_pkg::REGION_INSTR;
         s_nxt.resp.phys_addr = i_phys; // R10
      end else if (d_in) begin
         s_nxt.resp.grant = d_grant; // R06
         s_nxt.resp.region = mpu_mmu_pkg::REGION_DATA;
         s_nxt.resp.phys_addr = d_phys; // R10
      end
      // A denied access never carries a usable address to the arrays
      if (!s_nxt.resp.grant) begin
         s_nxt.resp.phys_addr = 32'h0000_0000;
      end

      // Violation capture: first fault is kept, a new fault beats a clear
      deny = acc_req.valid & ~s_nxt.resp.grant;
      if (clr_viol) begin
         s_nxt.viol = 1'b0;
         s_nxt.viol_cnt = 16'h0000;
      end
      if (deny) begin
         if (!s_r.viol || clr_viol) begin
            s_nxt.viol_pid = acc_req.process_ident;
            s_nxt.viol_wr = acc_req.write;
            s_nxt.viol_region = s_nxt.resp.region;
            s_nxt.viol_addr = acc_req.addr;
         end
         s_nxt.viol = 1'b1;
         // Saturates so software never mistakes a wrap for a quiet period
         if (clr_viol) begin
            s_nxt.viol_cnt = 16'h0001;
         end else if (s_r.viol_cnt != mpu_mmu_pkg::VCNT_MAX) begin
            s_nxt.viol_cnt = s_r.viol_cnt + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.fast_allow <= mpu_mmu_pkg::FAST_ALLOW_RST;
         s_r.slow_allow <= mpu_mmu_pkg::SLOW_ALLOW_RST;
         s_r.ipsz <= mpu_mmu_pkg::PSZ_RST;
         s_r.dpsz <= mpu_mmu_pkg::PSZ_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state flops
   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.rdat;
   assign acc_resp = s_r.resp;

endmodule
`default_nettype wire

// ===== dv/mem_guard_checker.sv
// Concurrent port checks for the memory guard
`default_nettype none
module mem_guard_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire mpu_mmu_pkg::acc_req_t acc_req,
   input wire mpu_mmu_pkg::acc_resp_t acc_resp
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic os;
   logic in_i;
   logic in_d;
   logic in_slow;
   logic [31:0] addr_r;
   // Window decode by upper address bits, kept apart from the design's helpers
   assign os = acc_req.process_ident[2:1] == 2'h0;
   assign in_i = acc_req.addr[31:17] == 15'h2004;
   assign in_d = acc_req.addr[31:17] == 15'h1FFE;
   assign in_slow = acc_req.addr[31:13] == 19'h28000;
   // Request address one cycle late, to line up with the response
   always_ff @(posedge clk) begin
      addr_r <= acc_req.addr;
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged after one cycle");
   ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held longer than one cycle");
   dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside acknowledge");
   resp_follows_a: assert property (acc_resp.valid == $past(acc_req.valid))
      else $error("response valid not one cycle after request");
   slow_os_grant_a: assert property (acc_req.valid && os && in_slow |=> acc_resp.grant)
      else $error("os id refused on slow memory");
   os_identity_a: assert property (acc_req.valid && os && (in_i || in_d) |=>
      acc_resp.grant && acc_resp.phys_addr == addr_r) else $error("os access not identity mapped");
   instr_ro_a: assert property (acc_req.valid && !os && acc_req.write && in_i |=> !acc_resp.grant)
      else $error("application write granted on instruction side");
   data_offset_a: assert property (acc_resp.valid && acc_resp.grant && acc_resp.region ==
      mpu_mmu_pkg::REGION_DATA |-> acc_resp.phys_addr[10:0] == addr_r[10:0] &&
      acc_resp.phys_addr[31:17] == 15'h1FFE) else $error("data translation broke offset or window");
endmodule
bind mem_guard mem_guard_checker u_chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .acc_req(acc_req), .acc_resp(acc_resp));
`default_nettype wire

// ===== dv/cpu_access_model.sv
// Behavioural CPU bus issuing process-tagged accesses
`default_nettype none
module cpu_access_model (
   input wire logic clk,
   output var mpu_mmu_pkg::acc_req_t acc_req,
   input wire mpu_mmu_pkg::acc_resp_t acc_resp
);
   initial acc_req = '0;
   // One access held for one edge; the idle bus is scrambled so stale values never look valid
   task automatic access(input logic [2:0] process_ident, input logic [31:0] addr, input logic wr,
      output mpu_mmu_pkg::acc_resp_t resp);
      @(posedge clk);
      acc_req <= '{valid: 1'b1, write: wr, process_ident: process_ident, addr: addr};
      @(posedge clk);
      acc_req <= '{valid: 1'b0, write: ~wr, process_ident: ~process_ident, addr: ~addr};
      @(negedge clk);
      resp = acc_resp;
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the memory guard
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // Region codes: 0 none, 1 fast, 2 slow, 3 instr, 4 data
   typedef struct packed {
      logic [2:0] process_ident;
      logic [31:0] addr;
      logic wr;
      logic grant;
      logic [2:0] region;
      logic [31:0] phys;
   } row_t;
   logic clk;
   logic sys_rst;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [2:0] wb_pid_i;
   logic wb_ack_o;
   logic [31:0] wb_dat_o;
   mpu_mmu_pkg::acc_req_t acc_req;
   mpu_mmu_pkg::acc_resp_t acc_resp;
   mpu_mmu_pkg::acc_resp_t rsp;
   logic [31:0] rd;
   logic [31:0] sz;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   row_t rows [8];
   mem_guard uut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_pid_i(wb_pid_i), .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o), .acc_req(acc_req), .acc_resp(acc_resp));
   cpu_access_model u_cpu (.clk(clk), .acc_req(acc_req), .acc_resp(acc_resp));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic wrap_up();
      $display("counts: %0d checks, %0d mismatches", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One access through the CPU model, whole response compared
   task automatic acc(input row_t r);
      mpu_mmu_pkg::acc_resp_t exp;
      exp = '{1'b1, r.grant, r.wr, mpu_mmu_pkg::region_t'(r.region), r.phys};
      u_cpu.access(r.process_ident, r.addr, r.wr, rsp);
      n_tests++;
      if (rsp !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, rsp, exp);
      end
   endtask
   // Classic single cycle; waits for ack without assuming its latency
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] p);
      int n;
      n = 0;
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_pid_i} <= {2'b11, w, a, d, p};
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n == 20) begin
         failures++;
         wrap_up();
      end
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} <= {2'b00, ~a, ~d};
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0, 3'h0);
      chk32(rd, exp);
   endtask
   // ----------------------------------------
   // Clock, ceiling and main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         wrap_up();
      end
   end
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_pid_i} = '0;
      wb_sel_i = 4'h1;
      sys_rst = 1'b1;
      rows = '{'{3'h0, 32'h3FF8_0010, 1'b0, 1'b1, 3'h1, 32'h3FF8_0010},
         '{3'h1, 32'h400C_1FFC, 1'b1, 1'b1, 3'h1, 32'h400C_1FFC}, '{3'h2, 32'h400C_0000, 1'b0, 1'b0, 3'h1, 32'h0},
         '{3'h1, 32'h5000_1FFF, 1'b1, 1'b1, 3'h2, 32'h5000_1FFF}, '{3'h7, 32'h5000_0000, 1'b0, 1'b0, 3'h2, 32'h0},
         '{3'h1, 32'h4009_FFF0, 1'b1, 1'b1, 3'h3, 32'h4009_FFF0}, '{3'h3, 32'h3FFC_2345, 1'b0, 1'b0, 3'h4, 32'h0},
         '{3'h5, 32'h1000_0000, 1'b0, 1'b1, 3'h0, 32'h1000_0000}};
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rows[i]) acc(rows[i]);
      $display("test default table done");
      rdchk(8'h00, 32'h03);
      rdchk(8'h04, 32'h00);
      rdchk(8'h48, 32'h00);
      rdchk(8'h3C, 32'h00);
      // Denial capture keeps the first fault (id 2 reading fast memory) and counts all three
      rdchk(8'h10, 32'h0000_1021);
      rdchk(8'h14, 32'h400C_0000);
      rdchk(8'h18, 32'h0000_0003);
      wb(1'b1, 8'h10, 32'h01, 3'h1);
      rdchk(8'h10, 32'h0000_1020);
      rdchk(8'h18, 32'h0000_0000);
      $display("test reset values done");
      // Allow bits: refused writers first, then a single-id grant
      wb(1'b1, 8'h00, 32'hFF, 3'h1);
      rdchk(8'h00, 32'h03);
      wb(1'b1, 8'h00, 32'h04, 3'h0);
      acc('{3'h2, 32'h3FF8_1FFF, 1'b1, 1'b1, 3'h1, 32'h3FF8_1FFF});
      acc('{3'h3, 32'h400C_0004, 1'b0, 1'b0, 3'h1, 32'h0});
      acc('{3'h0, 32'h3FF8_0000, 1'b0, 1'b0, 3'h1, 32'h0});
      wb(1'b1, 8'h04, 32'h3F, 3'h2);
      wb(1'b1, 8'h04, 32'h02, 3'h1);
      rdchk(8'h04, 32'h02);
      acc('{3'h3, 32'h5000_0100, 1'b1, 1'b1, 3'h2, 32'h5000_0100});
      acc('{3'h2, 32'h5000_0100, 1'b0, 1'b0, 3'h2, 32'h0});
      $display("test retention allow done");
      // Data side: virtual page 1 to physical page 2 for id 3 only
      wb(1'b1, 8'h88, 32'h31, 3'h0);
      wb(1'b1, 8'h8C, 32'h11, 3'h2);
      rdchk(8'h8C, 32'h00);
      acc('{3'h3, 32'h3FFC_2345, 1'b1, 1'b1, 3'h4, 32'h3FFC_4345});
      acc('{3'h4, 32'h3FFC_2345, 1'b0, 1'b0, 3'h4, 32'h0});
      $display("test data map done");
      // Instruction side: physical page 15 open to all apps at each page size
      wb(1'b1, 8'h7C, 32'h10, 3'h0);
      for (int s = 0; s < 3; s++) begin
         sz = 32'h2000 >> s;
         wb(1'b1, 8'h08, 32'(s), 3'h1);
         rdchk(8'h0C, 32'h00);
         acc('{3'h6, 32'h4008_07F4, 1'b0, 1'b1, 3'h3, 32'h4008_07F4 + 15 * sz});
         acc('{3'h6, 32'h4008_07F4, 1'b1, 1'b0, 3'h3, 32'h0});
         if (s > 0) acc('{3'h6, 32'h4008_0000 + 16 * sz, 1'b0, 1'b0, 3'h3, 32'h0});
         acc('{3'h1, 32'h4009_FFFC, 1'b1, 1'b1, 3'h3, 32'h4009_FFFC});
      end
      $display("test page sizes done");
      // Second reset in mid-run restores the configuration; driven on a rising edge
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      rdchk(8'h00, 32'h03);
      rdchk(8'h08, 32'h00);
      rdchk(8'h04, 32'h00);
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
